// file: common/htfd_pkg.sv
// package: constants and types of the host transport frame decoder
// Operation
// [R01] a frame is one 16-bit command word, then zero or more data words
// [R02] parallel and serial ports feed one shared command decoder
// [R03] address is 8-bit page plus 7-bit offset, 16-bit locations
// [R04] up to 257 pages of 128 locations each
// [R05] non-direct accesses use the page register, changed only by page select
// [R06] direct access reaches the direct page and leaves the page register alone
// [R07] page select loads the command low byte into the page register
// [R08] paged offset access starts at the 7-bit offset on the current page
// [R09] length plus one data words follow, 1 to 128 locations; start and continue take 8-bit lengths, up to 256
// [R10] address increments after each data word
// [R11] read/write bit: 0 reads, 1 writes
// [R12] host keeps direct page offsets within 0 to 119
// [R13] host port sustains 16-bit words at up to 10 MHz
// [R14] data words move over the internal bus like a host-driven dma
// [R15] parallel port is 8 or 16 bits, width and strobes from config pins
// [R16] serial port is a 4-wire synchronous slave carrying the same frames
// [R17] start paged access begins at offset zero, 8-bit length
// [R18] continue paged access resumes after the last paged word
// [R19] configure command stores wait, interrupt drive and byte order options
// [R20] bit 15 clear is paged offset; high byte below f8 is direct offset
// [R21] f8/f9 start, fa/fb continue, fd configure, fe page, ffff no-op
// [R22] no-op touches neither page register nor memory, no data words
package htfd_pkg;
  localparam int WORD_W = 16;
  localparam int SYS_HZ = 20_000_000;
  localparam int HOST_HZ = 10_000_000;
  localparam int WORD_CYC = SYS_HZ / HOST_HZ;
  localparam logic [8:0] DIRECT_PAGE = 9'h100;
  localparam logic [6:0] OFF_ZERO = 7'h00;
  localparam logic [7:0] DIRECT_LIMIT = 8'hf8;
  localparam logic [5:0] PAGED_STREAM = 6'h3e;
  localparam logic [7:0] CMD_CFG = 8'hfd;
  localparam logic [7:0] CMD_PAGE = 8'hfe;
  localparam logic [7:0] CMD_NOP = 8'hff;
  localparam int HI_LSB = 8;
  localparam int RW_BIT = 7;
  localparam int CFG_W = 5;
  localparam logic [2:0] CONF_SERIAL = 3'h4;
  localparam int CONF_SEP_BIT = 0;
  localparam int CONF_WIDE_BIT = 1;
  localparam int CONF_SER_BIT = 2;
  localparam logic [1:0] SETTLE = 2'h3;
  localparam logic [3:0] SPI_LAST = 4'hf;
  localparam logic [24:0] PIN_IDLE = {3'h0, 3'h7, 16'h0000, 3'h4};
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_FRAMES = 8'h08;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic int_ttl;
    logic wait_open;
    logic wait_en;
    logic wait_hi;
    logic little;
  } htfd_cfg_t;
  localparam htfd_cfg_t CFG_RST = '0;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } htfd_mem_t;
  typedef enum logic [2:0] {S_CMD, S_WDATA, S_WMEM, S_RMEM, S_RHOLD} htfd_state_t;
endpackage

// file: hdl/htfd_sync.sv
// module: two-flop synchroniser for pin inputs
module htfd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_r
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
endmodule // htfd_sync

// file: hdl/htfd_frame_decoder.sv
// module: host port transport frame decoder with register slave
module htfd_frame_decoder #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] conf_pins,
  input wire logic par_cs_b,
  input wire logic par_rd_b,
  input wire logic par_wr_b,
  input wire logic [15:0] par_din,
  output logic [15:0] par_dout,
  output logic par_oe,
  output logic wait_out,
  output logic wait_oe,
  input wire logic spi_cs_b,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output htfd_pkg::htfd_mem_t mem_out,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import htfd_pkg::*;

  if (ADDR_W < 4 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must lie between 4 and 8");
  end
  // pin sync costs two clocks, so the core clock must be at least twice the word rate
  if (WORD_CYC < 2) begin : g_rate // R13
    $error("system clock too slow for the host word rate");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 25;
  logic [SYNC_W-1:0] pin_s;
  wire logic [SYNC_W-1:0] pin_raw = {conf_pins, par_cs_b, par_rd_b, par_wr_b, par_din,
                                     spi_cs_b, spi_sclk, spi_mosi};
  htfd_sync #(.WIDTH(SYNC_W), .RST_VAL(PIN_IDLE)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d_in(pin_raw),
    .q_r(pin_s)
  );
  wire logic [2:0] conf_s = pin_s[24:22];
  wire logic pcs_b_s = pin_s[21];
  wire logic prd_b_s = pin_s[20];
  wire logic pwr_b_s = pin_s[19];
  wire logic [15:0] pdin_s = pin_s[18:3];
  wire logic scs_b_s = pin_s[2];
  wire logic sck_s = pin_s[1];
  wire logic mosi_s = pin_s[0];

  // ----------------------------------------------------------------
  // strap capture and port mode
  // ----------------------------------------------------------------
  logic [1:0] settle_r;
  logic [2:0] mode_r;
  logic ctrl_en_r;
  // straps follow the pins until settled, then freeze
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= '0;
      mode_r <= '0;
    end else if (settle_r != SETTLE) begin
      settle_r <= settle_r + 2'h1;
      mode_r <= conf_s;
    end
  end
  wire logic port_on = ctrl_en_r & (settle_r == SETTLE);
  wire logic ser_mode = (mode_r == CONF_SERIAL); // R16
  wire logic par_mode = ~mode_r[CONF_SER_BIT]; // R15
  wire logic wide = mode_r[CONF_WIDE_BIT];
  wire logic sep = mode_r[CONF_SEP_BIT];

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  htfd_state_t st_r;
  htfd_cfg_t cfg_r;
  logic [7:0] page_r;
  logic [15:0] addr_r, cont_r, tx_r, wdata_r, frames_r;
  logic [8:0] cnt_r;
  logic we_r, paged_r, req_r;

  // ----------------------------------------------------------------
  // parallel port
  // ----------------------------------------------------------------
  logic p_rd_r, p_wr_r, ph_r;
  logic [7:0] byte_r;
  logic [15:0] dlat_r;
  wire logic p_cs = ~pcs_b_s & par_mode & port_on;
  // combined style: write strobe is the data strobe, read line is r/w level
  wire logic p_rd = p_cs & (sep ? ~prd_b_s : (~pwr_b_s & prd_b_s)); // R15
  wire logic p_wr = p_cs & (sep ? ~pwr_b_s : (~pwr_b_s & ~prd_b_s)); // R15
  wire logic p_rd_end = p_rd_r & ~p_rd;
  wire logic p_wr_end = p_wr_r & ~p_wr;
  wire logic p_word = wide | ph_r;
  wire logic par_rx_v = p_wr_end & p_word;
  wire logic par_take = p_rd_end & p_word;
  wire logic [15:0] par_rx_w = wide ? dlat_r :
                               (cfg_r.little ? {dlat_r[7:0], byte_r} : {byte_r, dlat_r[7:0]});
  wire logic sel_hi = ~(ph_r ^ cfg_r.little);
  wire logic [7:0] tx_byte = sel_hi ? tx_r[15:8] : tx_r[7:0];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_rd_r <= 1'b0;
      p_wr_r <= 1'b0;
      ph_r <= 1'b0;
      byte_r <= '0;
      dlat_r <= '0;
    end else begin
      p_rd_r <= p_rd;
      p_wr_r <= p_wr;
      // bus data is gone by the strobe's end, so keep it while active
      if (p_wr) begin
        dlat_r <= pdin_s;
      end
      if (!wide && (p_rd_end || p_wr_end)) begin
        ph_r <= ~ph_r;
        byte_r <= dlat_r[7:0];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_oe <= 1'b0;
      par_dout <= '0;
    end else begin
      par_oe <= p_rd;
      par_dout <= wide ? tx_r : {8'h00, tx_byte};
    end
  end

  // ----------------------------------------------------------------
  // serial port, mode 0, msb first
  // ----------------------------------------------------------------
  logic sck_r;
  logic [3:0] bit_r;
  logic [15:0] srx_r, stx_r;
  wire logic s_cs = ~scs_b_s & ser_mode & port_on;
  wire logic s_rise = s_cs & sck_s & ~sck_r;
  wire logic s_fall = s_cs & ~sck_s & sck_r;
  wire logic s_rx_v = s_rise & (bit_r == SPI_LAST); // R16
  wire logic [15:0] s_rx_w = {srx_r[14:0], mosi_s};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_r <= 1'b0;
      bit_r <= '0;
      srx_r <= '0;
      stx_r <= '0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      sck_r <= sck_s;
      spi_miso_oe <= s_cs;
      if (!s_cs) begin
        bit_r <= '0;
      end else if (s_rise) begin
        srx_r <= s_rx_w;
        bit_r <= bit_r + 4'h1;
      end
      // between words the shifter tracks the latest fetched word
      if (bit_r == 4'h0 && !sck_s) begin
        stx_r <= tx_r;
        spi_miso <= tx_r[15];
      end else if (s_fall) begin
        stx_r <= {stx_r[14:0], 1'b0};
        spi_miso <= stx_r[14];
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode, shared by both ports
  // ----------------------------------------------------------------
  wire logic rx_v = ser_mode ? s_rx_v : par_rx_v; // R02
  wire logic [15:0] rx_w = ser_mode ? s_rx_w : par_rx_w; // R02
  wire logic take = ser_mode ? s_rx_v : par_take;
  wire logic [7:0] hi = rx_w[15:HI_LSB];
  wire logic [7:0] lo = rx_w[7:0];
  wire logic [6:0] off = rx_w[14:HI_LSB];
  wire logic is_pofs = ~rx_w[15]; // R20
  wire logic is_dofs = rx_w[15] & (hi < DIRECT_LIMIT); // R20
  wire logic is_strm = (hi[7:2] == PAGED_STREAM); // R21
  wire logic is_cont = is_strm & hi[1]; // R21
  wire logic is_cfg = (hi == CMD_CFG); // R21
  wire logic is_page = (hi == CMD_PAGE); // R21
  wire logic is_xfer = is_pofs | is_dofs | is_strm;
  wire logic cmd_v = (st_r == S_CMD) & rx_v; // R01
  // paged offset and start targets use the page register, continue resumes at cont_r, direct targets page 256
  wire logic [15:0] x_base = is_pofs ? {1'b0, page_r, off} : // R08 R05 R03
                             is_dofs ? {DIRECT_PAGE, off} : // R06 R04
                             is_cont ? cont_r : // R18
                             {1'b0, page_r, OFF_ZERO}; // R17
  wire logic [8:0] x_len = is_strm ? {1'b0, lo} : {2'b00, rx_w[6:0]}; // R09 R17
  wire logic x_we = is_strm ? hi[0] : rx_w[RW_BIT]; // R11
  wire logic last = (cnt_r == 9'h001);
  wire logic busy = (st_r == S_WMEM) | (st_r == S_RMEM);

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_CMD;
      page_r <= '0;
      cfg_r <= CFG_RST;
      addr_r <= '0;
      cont_r <= '0;
      cnt_r <= '0;
      we_r <= 1'b0;
      paged_r <= 1'b0;
      req_r <= 1'b0;
      wdata_r <= '0;
      tx_r <= '0;
      frames_r <= '0;
    end else begin
      case (st_r)
        S_CMD: begin
          if (rx_v && is_xfer) begin
            addr_r <= x_base;
            cnt_r <= x_len + 9'h001; // R09
            we_r <= x_we; // R11
            paged_r <= ~is_dofs;
            req_r <= ~x_we; // R14
            st_r <= x_we ? S_WDATA : S_RMEM;
          end else if (rx_v && is_page) begin
            page_r <= lo; // R07
          end else if (rx_v && is_cfg) begin
            cfg_r <= lo[CFG_W-1:0]; // R19
          end
        end
        S_WDATA: begin
          if (rx_v) begin
            wdata_r <= rx_w; // R14
            req_r <= 1'b1;
            st_r <= S_WMEM;
          end
        end
        S_WMEM, S_RMEM: begin
          if (mem_ack) begin
            req_r <= 1'b0;
            // resume point for a later continue access
            if (paged_r) begin
              cont_r <= addr_r + 16'h0001; // R18
            end
            if (st_r == S_RMEM) begin
              tx_r <= mem_rdata; // R14
              st_r <= S_RHOLD;
            end else begin
              cnt_r <= cnt_r - 9'h001;
              addr_r <= addr_r + 16'h0001; // R10
              st_r <= last ? S_CMD : S_WDATA;
              frames_r <= last ? frames_r + 16'h0001 : frames_r;
            end
          end
        end
        S_RHOLD: begin
          if (take) begin
            cnt_r <= cnt_r - 9'h001;
            addr_r <= addr_r + 16'h0001; // R10
            req_r <= ~last;
            st_r <= last ? S_CMD : S_RMEM;
            frames_r <= last ? frames_r + 16'h0001 : frames_r;
          end
        end
        default: st_r <= S_CMD;
      endcase
    end
  end
  assign mem_out = '{req: req_r, we: we_r, addr: addr_r, wdata: wdata_r};

  // ----------------------------------------------------------------
  // wait pin: asserted while a word is in flight on the internal bus and the parallel port is selected
  // ----------------------------------------------------------------
  wire logic w_act = busy & p_cs;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_out <= 1'b1;
      wait_oe <= 1'b0;
    end else begin
      wait_out <= w_act ^ ~cfg_r.wait_hi; // R19
      wait_oe <= cfg_r.wait_en & (~cfg_r.wait_open | w_act); // R19
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic aw_got_r, w_got_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  wire logic [7:0] awa = 8'(s_axi_awaddr);
  wire logic [7:0] ara = 8'(s_axi_araddr);
  wire logic w_map = (awa_r == REG_CTRL) | (awa_r == REG_STAT) | (awa_r == REG_FRAMES);
  wire logic r_map = (ara == REG_CTRL) | (ara == REG_STAT) | (ara == REG_FRAMES);
  wire logic [31:0] stat_w = {16'h0000, (settle_r == SETTLE), ser_mode, (st_r != S_CMD),
                              cfg_r, page_r};
  wire logic [31:0] rd_w = (ara == REG_CTRL) ? {31'h0, ctrl_en_r} :
                           (ara == REG_STAT) ? stat_w :
                           (ara == REG_FRAMES) ? {16'h0000, frames_r} : 32'h0;
  wire logic do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      ctrl_en_r <= CTRL_EN_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awa_r <= awa;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_map ? RESP_OK : RESP_SLVERR;
        if (awa_r == REG_CTRL && ws_r[0]) begin
          ctrl_en_r <= wd_r[0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_w;
      s_axi_rresp <= r_map ? RESP_OK : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  page_load_a: assert property (cmd_v && is_page |=> page_r == $past(lo)) // R07
    else $error("page select did not load page");
  page_keep_a: assert property (!(cmd_v && is_page) |=> $stable(page_r)) // R05
    else $error("page register changed without page select");
  direct_addr_a: assert property (cmd_v && is_dofs |=> addr_r[15:7] == DIRECT_PAGE) // R06
    else $error("direct access missed direct page");
  paged_addr_a: assert property (
    cmd_v && is_pofs |=> addr_r == {1'b0, $past(page_r), $past(off)}) // R08
    else $error("paged offset address wrong");
  start_zero_a: assert property (
    cmd_v && is_strm && !is_cont |=> addr_r[6:0] == OFF_ZERO) // R17
    else $error("start paged access not at offset zero");
  len_count_a: assert property (
    cmd_v && is_xfer |=> cnt_r == $past(x_len) + 9'h001 ##0 we_r == $past(x_we)) // R09
    else $error("word count or direction wrong");
  addr_step_a: assert property (
    st_r == S_WMEM && mem_ack && !last |=> addr_r == $past(addr_r) + 16'h0001) // R10
    else $error("address did not increment");
  req_hold_a: assert property (
    mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr)) // R14
    else $error("bus request dropped before acknowledge");
  nop_idle_a: assert property (
    cmd_v && hi == CMD_NOP |=> st_r == S_CMD && !mem_out.req) // R22
    else $error("no-op started a transfer");
  rw_dir_a: assert property (
    mem_out.req && st_r == S_WMEM |-> mem_out.we) // R11
    else $error("write word issued as read");

  wr_frame_c: cover property (st_r == S_WMEM && mem_ack && last);
  rd_frame_c: cover property (st_r == S_RHOLD && take && last);
  page_sel_c: cover property (cmd_v && is_page);
  cont_c: cover property (cmd_v && is_cont);
endmodule // htfd_frame_decoder

// file: testbench/htfd_mem_model.sv
// internal memory partner: answers the frame decoder's bus requests
module htfd_mem_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire htfd_pkg::htfd_mem_t mem_out,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  import htfd_pkg::*;
  // ----------------------------------------
  // answer logic
  // ----------------------------------------
  logic [2:0] wait_r;
  logic slow_r;
  // alternates prompt and slow answers; read data is a function of the address
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 3'h0;
      slow_r <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      // data outside an answer is not held, so a late sample cannot pass by luck
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack) begin
        if (wait_r == (slow_r ? 3'h3 : 3'h0)) begin
          mem_ack <= 1'b1;
          mem_rdata <= mem_out.addr ^ 16'ha5c3;
          wait_r <= 3'h0;
          slow_r <= !slow_r;
        end else begin
          wait_r <= wait_r + 3'h1;
        end
      end
    end
  end
endmodule // htfd_mem_model

// file: testbench/tb_host_transport_frame_decoder.sv
// testbench: frame decoder driven as host over parallel, serial and register bus
module tb_host_transport_frame_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import htfd_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] conf_pins = 3'h3;
  logic par_cs_b = 1'b1, par_rd_b = 1'b1, par_wr_b = 1'b1;
  logic [15:0] par_din = 16'h0000;
  logic [15:0] par_dout, mem_rdata;
  logic par_oe, mem_ack;
  logic wait_out, wait_oe, spi_miso, spi_miso_oe;
  logic spi_cs_b = 1'b1, spi_sclk = 1'b0, spi_mosi = 1'b0;
  htfd_mem_t mem_out;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  bit ser_mode = 1'b0;
  int errors = 0, n_checks = 0, cycles = 0;
  always #25 sys_clk = ~sys_clk;
  htfd_frame_decoder #(.ADDR_W(8)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .conf_pins(conf_pins), .par_cs_b(par_cs_b), .par_rd_b(par_rd_b), .par_wr_b(par_wr_b),
    .par_din(par_din), .par_dout(par_dout), .par_oe(par_oe), .wait_out(wait_out),
    .wait_oe(wait_oe), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mem_out(mem_out), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  htfd_mem_model mem_u (.sys_clk(sys_clk), .rst_b(rst_b), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_mem(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t mem got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // every bus access must match the oldest noted access; read data is masked
  always @(posedge sys_clk) begin
    if (rst_b && mem_out.req && mem_ack) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
      chk_mem({mem_out.we, mem_out.addr, mem_out.we ? mem_out.wdata : 16'h0000}, note);
    end
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // host side drivers
  // ----------------------------------------
  task automatic do_reset(input logic [2:0] conf);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    conf_pins <= conf;
    ser_mode = (conf == CONF_SERIAL);
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    // strap needs sync and settle time before the first word
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic send_word(input logic [15:0] w);
    if (ser_mode) begin
      @(posedge sys_clk);
      spi_cs_b <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
        spi_mosi <= w[i];
        repeat (3) @(posedge sys_clk);
        spi_sclk <= 1'b1;
        repeat (3) @(posedge sys_clk);
        spi_sclk <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      spi_cs_b <= 1'b1;
    end else begin
      // byte mode sends the high byte first; combined style holds r/w low for a write
      for (int b = int'(conf_pins[1]); b < 2; b++) begin
        @(posedge sys_clk);
        par_cs_b <= 1'b0;
        par_rd_b <= conf_pins[0];
        par_din <= (b == 0) ? {8'h00, w[15:8]} : w;
        par_wr_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        par_wr_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        par_cs_b <= 1'b1;
        par_rd_b <= 1'b1;
      end
    end
    // pacing instead of watching wait, slower than the slowest memory answer
    repeat (14) @(posedge sys_clk);
  endtask
  task automatic frame(input logic [15:0] cmd, input logic [15:0] base, input int n,
                       input logic we);
    logic [15:0] d[$];
    for (int i = 0; i < n; i++) begin
      d.push_back(16'($urandom));
      exp_q.push_back({we, base + 16'(i), we ? d[i] : 16'h0000});
    end
    send_word(cmd);
    if (we) begin
      foreach (d[i]) send_word(d[i]);
    end
  endtask
  task automatic rd_word(input logic [15:0] e);
    @(posedge sys_clk);
    par_cs_b <= 1'b0;
    par_rd_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk_val({31'h0, par_oe}, 32'h0000_0001);
    par_rd_b <= 1'b1;
    par_cs_b <= 1'b1;
    repeat (14) @(posedge sys_clk);
    chk_val({16'h0000, par_dout}, {16'h0000, e});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_val({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_val({30'h0, s_axi_rresp}, {30'h0, er});
    if (er == RESP_OK) chk_val(s_axi_rdata, ed);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(89));
    do_reset(3'h3);
    axi_wr(REG_CTRL, 32'h0000_0001, RESP_OK);
    axi_wr(8'h0c, 32'h0000_0000, RESP_SLVERR);
    axi_rd(8'h0c, 32'h0000_0000, RESP_SLVERR);
    $display("test register bus done");
    frame(16'hfe05, 16'h0000, 0, 1'b1);
    frame(16'h7e82, 16'h02fe, 3, 1'b1);
    frame(16'h00ff, 16'h0280, 128, 1'b1);
    frame(16'hf780, 16'h8077, 1, 1'b1);
    frame(16'hffff, 16'h0000, 0, 1'b1);
    frame(16'hf901, 16'h0280, 2, 1'b1);
    frame(16'hfb00, 16'h0282, 1, 1'b1);
    frame(16'hfd06, 16'h0000, 0, 1'b1);
    chk_val({30'h0, wait_oe, wait_out}, 32'h0000_0002);
    axi_rd(REG_STAT, 32'h0000_8605, RESP_OK);
    $display("test parallel writes done");
    frame(16'h0300, 16'h0283, 1, 1'b0);
    rd_word(16'h0283 ^ 16'ha5c3);
    axi_rd(REG_FRAMES, 32'h0000_0006, RESP_OK);
    $display("test parallel read done");
    do_reset(3'h0);
    frame(16'hfe02, 16'h0000, 0, 1'b1);
    frame(16'h1081, 16'h0110, 2, 1'b1);
    $display("test byte port done");
    do_reset(CONF_SERIAL);
    frame(16'hfe07, 16'h0000, 0, 1'b1);
    frame(16'h0a80, 16'h038a, 1, 1'b1);
    frame(16'h0a00, 16'h038a, 1, 1'b0);
    chk_val({30'h0, spi_miso_oe, (16'h038a ^ 16'ha5c3) >= 16'h8000}, 32'h1);
    send_word(16'h0000);
    repeat (20) @(posedge sys_clk);
    $display("test serial port done");
    chk_val(32'(exp_q.size()), 32'h0000_0000);
    wrap_up();
  end
endmodule // tb_host_transport_frame_decoder
